/* hw/drive_stop_dwell_boost_control.sv */
`timescale 1ns/100ps
module drive_stop_dwell_boost_control
  import drive_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC, // cycles per hold tick
  parameter logic [15:0] BOOST_KNEE = 16'h1388 // boost drops to zero above this
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // operator terminals (asynchronous pins)
  input wire logic permit_pin,
  // motor stage
  output logic [15:0] out_freq,
  output logic [15:0] out_boost,
  output logic out_enable,
  output logic out_reverse
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [1:0] permit_sync; // two-stage pin synchroniser
    logic wr_pend; // pending write data phase
    logic rd_pend; // pending read data phase
    logic [7:0] addr; // latched address
    logic [31:0] rdata; // read data
    logic [5:0] ctrl; // control word
    logic [15:0] target; // target frequency, 0.01 Hz
    logic [15:0] ramp_step; // normal step per tick
    logic [15:0] halt_step; // quick-stop step per tick
    logic [15:0] acc_freq; // acceleration hold frequency
    logic [15:0] acc_time; // acceleration hold time, ticks
    logic [15:0] dec_freq; // deceleration hold frequency
    logic [15:0] dec_time; // deceleration hold time, ticks
    logic [7:0] fwd_boost; // forward boost, 0.1 percent
    logic [7:0] rev_boost; // reverse boost, 0.1 percent
    mode_t mode; // ramp state
    logic [15:0] freq; // frequency accumulator
    logic [15:0] hold_cnt; // hold tick counter
    logic [31:0] tick_cnt; // tick prescaler
    logic acc_done; // accel hold already spent this run
    logic latched_off; // quick stop latched until new run
    logic quick; // quick-stop ramp active
    logic run_prev; // run bit, previous cycle
    logic enable; // output bridge enable
  } state_t;

  state_t cur_q;
  state_t nxt_d;

  // ==========================================================
  // helpers
  // clamp a hold point in rpm mode to its legal span
  function automatic logic [15:0] clamp_hold(input logic [15:0] v, input logic rpm);
    clamp_hold = (rpm && v > HOLD_SPEED_MAX) ? HOLD_SPEED_MAX : v;
  endfunction : clamp_hold

  // clamp a boost setting to its legal span
  function automatic logic [7:0] clamp_boost(input logic [7:0] v);
    clamp_boost = (v > BOOST_MAX) ? BOOST_MAX : v;
  endfunction : clamp_boost

  // step toward a limit without overshoot
  function automatic logic [15:0] step_to(input logic [15:0] f, input logic [15:0] lim,
                                           input logic [15:0] s);
    if (f < lim) begin
      step_to = (lim - f > s) ? f + s : lim;
    end else begin
      step_to = (f - lim > s) ? f - s : lim;
    end
  endfunction : step_to

  // ==========================================================
  // next-state logic
  always_comb begin
    logic permit_ok;
    logic run_cmd;
    logic tick;
    logic [1:0] stop_sel;
    logic rpm;
    logic [15:0] acc_pt;
    logic [15:0] dec_pt;
    logic [15:0] step;
    nxt_d = cur_q;
    permit_ok = 1'b1;
    run_cmd = 1'b0;
    tick = 1'b0;
    stop_sel = 2'h0;
    rpm = 1'b0;
    acc_pt = 16'h0000;
    dec_pt = 16'h0000;
    step = 16'h0000;
    // pin synchroniser, stage two only is read
    nxt_d.permit_sync = {cur_q.permit_sync[0], permit_pin};
    // bus address phase
    if (hsel && hready && htrans[1]) begin
      nxt_d.wr_pend = hwrite;
      nxt_d.rd_pend = !hwrite;
      nxt_d.addr = haddr[7:0];
    end else if (hready) begin
      nxt_d.wr_pend = 1'b0;
      nxt_d.rd_pend = 1'b0;
    end
    // bus write data phase
    if (cur_q.wr_pend) begin
      case (cur_q.addr)
        CTRL_OFS: nxt_d.ctrl = hwdata[5:0];
        TARGET_OFS: nxt_d.target = hwdata[15:0];
        RAMP_OFS: nxt_d.ramp_step = hwdata[15:0];
        HALT_OFS: nxt_d.halt_step = hwdata[15:0];
        ACC_HOLD_OFS: begin
          nxt_d.acc_freq = hwdata[15:0];
          nxt_d.acc_time = hwdata[31:16];
        end
        DEC_HOLD_OFS: begin
          nxt_d.dec_freq = hwdata[15:0];
          nxt_d.dec_time = hwdata[31:16];
        end
        BOOST_OFS: begin
          nxt_d.fwd_boost = clamp_boost(hwdata[7:0]);
          nxt_d.rev_boost = clamp_boost(hwdata[15:8]);
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
    // bus read data, captured at the address phase; settings come from the
    // post-write copy so a read right behind a write sees the new value
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFS: nxt_d.rdata = {26'h0, nxt_d.ctrl};
        TARGET_OFS: nxt_d.rdata = {16'h0, nxt_d.target};
        RAMP_OFS: nxt_d.rdata = {16'h0, nxt_d.ramp_step};
        HALT_OFS: nxt_d.rdata = {16'h0, nxt_d.halt_step};
        ACC_HOLD_OFS: nxt_d.rdata = {nxt_d.acc_time, nxt_d.acc_freq};
        DEC_HOLD_OFS: nxt_d.rdata = {nxt_d.dec_time, nxt_d.dec_freq};
        BOOST_OFS: nxt_d.rdata = {16'h0, nxt_d.rev_boost, nxt_d.fwd_boost};
        STATUS_OFS: nxt_d.rdata = {22'h0, cur_q.latched_off, cur_q.quick,
                                   cur_q.acc_done, cur_q.enable, cur_q.mode};
        FREQ_OFS: nxt_d.rdata = {16'h0, cur_q.freq};
        VOLT_OFS: nxt_d.rdata = {16'h0, out_boost};
        default: nxt_d.rdata = 32'h0000_0000;
      endcase
    end
    // decode of the configuration
    stop_sel = cur_q.ctrl[CTRL_STOPSEL_LSB +: 2];
    rpm = cur_q.ctrl[CTRL_RPM_BIT];
    acc_pt = clamp_hold(cur_q.acc_freq, rpm);
    dec_pt = clamp_hold(cur_q.dec_freq, rpm);
    if (cur_q.ctrl[CTRL_PERMIT_BIT]) begin
      permit_ok = cur_q.permit_sync[1];
    end
    // tick prescaler
    if (cur_q.tick_cnt >= TICK_CYCLES - 1) begin
      nxt_d.tick_cnt = 32'h0000_0000;
      tick = 1'b1;
    end else begin
      nxt_d.tick_cnt = cur_q.tick_cnt + 32'h0000_0001;
    end
    // a fresh run edge clears the quick-stop latch; accel hold rearms in idle
    nxt_d.run_prev = cur_q.ctrl[CTRL_RUN_BIT];
    if (cur_q.ctrl[CTRL_RUN_BIT] && !cur_q.run_prev) begin
      nxt_d.latched_off = 1'b0;
    end
    run_cmd = cur_q.ctrl[CTRL_RUN_BIT] && !cur_q.latched_off && permit_ok;
    if (!cur_q.ctrl[CTRL_RUN_BIT]) begin
      nxt_d.quick = 1'b0;
    end
    // permit loss handling
    if (cur_q.ctrl[CTRL_RUN_BIT] && !permit_ok && cur_q.mode != ST_IDLE) begin
      if (stop_sel == STOP_COAST) begin
        nxt_d.mode = ST_IDLE;
        nxt_d.freq = 16'h0000;
        nxt_d.enable = 1'b0;
      end else begin
        nxt_d.quick = 1'b1;
        if (stop_sel == STOP_QUICK) begin
          nxt_d.latched_off = 1'b1;
        end
      end
    end
    // quick-stop step for every choice but coast
    step = (cur_q.quick && stop_sel != STOP_COAST) ? cur_q.halt_step : cur_q.ramp_step;
    // ramp state machine
    if (!(cur_q.ctrl[CTRL_RUN_BIT] && !permit_ok && stop_sel == STOP_COAST)) begin
      case (cur_q.mode)
        ST_IDLE: begin
          nxt_d.freq = 16'h0000;
          nxt_d.enable = 1'b0;
          nxt_d.acc_done = 1'b0;
          if (run_cmd) begin
            nxt_d.mode = ST_ACCEL;
            nxt_d.enable = 1'b1;
            nxt_d.quick = 1'b0;
          end
        end
        ST_ACCEL, ST_RUN: begin
          if (!run_cmd) begin
            nxt_d.mode = ST_DECEL;
          end else if (tick) begin
            if (!cur_q.acc_done && cur_q.acc_time != 16'h0000 && acc_pt != 16'h0000
                && cur_q.freq < acc_pt && cur_q.target > acc_pt) begin
              nxt_d.freq = step_to(cur_q.freq, acc_pt, step);
              if (nxt_d.freq == acc_pt) begin
                nxt_d.mode = ST_ACC_HOLD;
                nxt_d.hold_cnt = 16'h0000;
              end
            end else begin
              nxt_d.freq = step_to(cur_q.freq, cur_q.target, step);
              nxt_d.mode = (nxt_d.freq == cur_q.target) ? ST_RUN : ST_ACCEL;
            end
          end
        end
        ST_ACC_HOLD: begin
          if (!run_cmd) begin
            nxt_d.mode = ST_DECEL;
            nxt_d.acc_done = 1'b1;
          end else if (tick) begin
            nxt_d.hold_cnt = cur_q.hold_cnt + 16'h0001;
            if (cur_q.hold_cnt + 16'h0001 >= cur_q.acc_time) begin
              nxt_d.mode = ST_ACCEL;
              nxt_d.acc_done = 1'b1;
            end
          end
        end
        ST_DECEL: begin
          if (run_cmd) begin
            nxt_d.mode = ST_ACCEL;
            nxt_d.acc_done = 1'b1;
          end else if (tick) begin
            if (cur_q.dec_time != 16'h0000 && dec_pt != 16'h0000
                && cur_q.freq > dec_pt) begin
              nxt_d.freq = step_to(cur_q.freq, dec_pt, step);
              if (nxt_d.freq == dec_pt) begin
                nxt_d.mode = ST_DEC_HOLD;
                nxt_d.hold_cnt = 16'h0000;
              end
            end else begin
              nxt_d.freq = step_to(cur_q.freq, 16'h0000, step);
              if (nxt_d.freq == 16'h0000) begin
                nxt_d.mode = ST_IDLE;
              end
            end
          end
        end
        ST_DEC_HOLD: begin
          if (tick) begin
            nxt_d.hold_cnt = cur_q.hold_cnt + 16'h0001;
            if (cur_q.hold_cnt + 16'h0001 >= cur_q.dec_time) begin
              nxt_d.freq = step_to(cur_q.freq, 16'h0000, step);
              nxt_d.mode = (nxt_d.freq == 16'h0000) ? ST_IDLE : ST_DECEL;
            end
          end
        end
        default: begin
          nxt_d.mode = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // state register, frozen while clk_en is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_q <= '{permit_sync: 2'h0, wr_pend: 1'b0, rd_pend: 1'b0, addr: 8'h00,
                 rdata: 32'h0000_0000, ctrl: CTRL_RST[5:0], target: TARGET_RST,
                 ramp_step: RAMP_RST, halt_step: HALT_RST, acc_freq: HOLD_FREQ_RST,
                 acc_time: HOLD_TIME_RST, dec_freq: HOLD_FREQ_RST,
                 dec_time: HOLD_TIME_RST, fwd_boost: BOOST_RST, rev_boost: BOOST_RST,
                 mode: ST_IDLE, freq: 16'h0000, hold_cnt: 16'h0000,
                 tick_cnt: 32'h0000_0000, acc_done: 1'b0, latched_off: 1'b0,
                 quick: 1'b0, run_prev: 1'b0, enable: 1'b0};
    end else if (clk_en) begin
      cur_q <= nxt_d;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign hrdata = cur_q.rdata;
  assign out_freq = cur_q.freq;
  assign out_enable = cur_q.enable;
  assign out_reverse = cur_q.ctrl[CTRL_REV_BIT];
  // manual boost: fixed amount below the knee, none when off
  assign out_boost = (cur_q.enable && cur_q.freq <= BOOST_KNEE)
                     ? {8'h00, (cur_q.ctrl[CTRL_REV_BIT] ? cur_q.rev_boost
                                                         : cur_q.fwd_boost)}
                     : 16'h0000;

endmodule : drive_stop_dwell_boost_control

/* hw/drive_ctl_pkg.sv */
package drive_ctl_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TARGET_OFS = 8'h04;
  localparam logic [7:0] RAMP_OFS = 8'h08;
  localparam logic [7:0] HALT_OFS = 8'h0C;
  localparam logic [7:0] ACC_HOLD_OFS = 8'h10;
  localparam logic [7:0] DEC_HOLD_OFS = 8'h14;
  localparam logic [7:0] BOOST_OFS = 8'h18;
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] FREQ_OFS = 8'h20;
  localparam logic [7:0] VOLT_OFS = 8'h24;
  // ==========================================================
  // ctrl fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_REV_BIT = 1;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_STOPSEL_LSB = 3;
  localparam int CTRL_RPM_BIT = 5;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TARGET_RST = 16'h0000;
  localparam logic [15:0] RAMP_RST = 16'h0001;
  localparam logic [15:0] HALT_RST = 16'h0004;
  localparam logic [15:0] HOLD_FREQ_RST = 16'h01F4;
  localparam logic [15:0] HOLD_SPEED_RST = 16'h0096;
  localparam logic [15:0] HOLD_SPEED_MAX = 16'h0708;
  localparam logic [15:0] HOLD_TIME_RST = 16'h0000;
  localparam logic [7:0] BOOST_RST = 8'h14;
  localparam logic [7:0] BOOST_MAX = 8'h96;
  // ==========================================================
  // permit-loss stop choices
  localparam logic [1:0] STOP_COAST = 2'h0;
  localparam logic [1:0] STOP_QUICK = 2'h1;
  localparam logic [1:0] STOP_RESUME = 2'h2;
  // hold timer tick: 1 ms at 125 MHz
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 8;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // ==========================================================
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ACCEL = 6'b000010,
    ST_ACC_HOLD = 6'b000100,
    ST_RUN = 6'b001000,
    ST_DECEL = 6'b010000,
    ST_DEC_HOLD = 6'b100000
  } mode_t;
endpackage : drive_ctl_pkg

/* testbench/drive_ctl_checker.sv */
`timescale 1ns/100ps
// ==========================================================
// port checker for the drive controller
module drive_ctl_checker
  import drive_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = 4, // cycles per hold tick
  parameter logic [15:0] BOOST_KNEE = 16'h1388 // boost fade point
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // terminals and motor stage
  input wire logic permit_pin,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_boost,
  input wire logic out_enable,
  input wire logic out_reverse
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // no wait states, always okay
  AST_NO_WAIT: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
  // read data only moves after a taken read
  AST_RDATA_STANDS: assert property (!$past(hsel && hready && htrans[1] && !hwrite && clk_en)
    |-> $stable(hrdata)) else $error("read data moved without read");
  // boost only on a live bridge
  AST_BOOST_OFF: assert property (!out_enable |-> out_boost == 16'h0000)
    else $error("boost with bridge off");
  AST_BOOST_RANGE: assert property (out_boost <= {8'h00, BOOST_MAX})
    else $error("boost above range");
  AST_BOOST_KNEE: assert property (out_freq > BOOST_KNEE |-> out_boost == 16'h0000)
    else $error("boost above low speed band");
  // coast leaves no frequency on an off bridge
  AST_OFF_ZERO: assert property (!out_enable |-> out_freq == 16'h0000)
    else $error("frequency on an off bridge");
  // ramp never steps on two cycles in a row
  AST_TICK_STEP: assert property (out_enable && $changed(out_freq) |=>
    !out_enable || $stable(out_freq)) else $error("ramp stepped twice in a row");
  // enable low freezes the outputs
  AST_FREEZE: assert property (!clk_en |=> $stable(out_freq) && $stable(out_enable))
    else $error("outputs moved while frozen");
endmodule : drive_ctl_checker
bind drive_stop_dwell_boost_control drive_ctl_checker #(
  .TICK_CYCLES(TICK_CYCLES), .BOOST_KNEE(BOOST_KNEE)) u_drive_ctl_checker (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .permit_pin(permit_pin),
  .out_freq(out_freq), .out_boost(out_boost), .out_enable(out_enable),
  .out_reverse(out_reverse));

/* testbench/motor_stage_model.sv */
`timescale 1ns/100ps
// ==========================================================
// operator permit terminal, switched off the clock edge
module motor_stage_model (
  // operator side
  input wire logic permit_req,
  output logic permit_pin
);
  // terminal starts closed
  initial permit_pin = 1'b1;
  // contact lands 3 ns late, unrelated to the clock
  always @(permit_req) permit_pin <= #3 permit_req;
endmodule : motor_stage_model

/* testbench/test_drive_stop_dwell_boost_control.sv */
`timescale 1ns/100ps
// ==========================================================
// self-checking bench
module test_drive_stop_dwell_boost_control;
  import drive_ctl_pkg::*;
  localparam logic [15:0] KNEE = 16'h1388; // boost fade point
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic permit_req = 1'b1, hready, hreadyout, hresp, permit_pin, out_enable, out_reverse;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] out_freq, out_boost, tg;
  logic [7:0] fw, rv;
  logic [5:0] seen;
  logic dir;
  int n_fail = 0, tests_run = 0;
  // reset value table, unmapped place last
  logic [7:0] ra [8] = '{CTRL_OFS, TARGET_OFS, RAMP_OFS, HALT_OFS, ACC_HOLD_OFS,
    DEC_HOLD_OFS, BOOST_OFS, 8'h40};
  logic [31:0] re [8] = '{CTRL_RST, {16'h0, TARGET_RST}, {16'h0, RAMP_RST},
    {16'h0, HALT_RST}, {HOLD_TIME_RST, HOLD_FREQ_RST}, {HOLD_TIME_RST, HOLD_FREQ_RST},
    {16'h0, BOOST_RST, BOOST_RST}, 32'h0};
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  drive_stop_dwell_boost_control #(.TICK_CYCLES(4), .BOOST_KNEE(KNEE))
    u_drive_stop_dwell_boost_control (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .permit_pin(permit_pin),
    .out_freq(out_freq), .out_boost(out_boost), .out_enable(out_enable),
    .out_reverse(out_reverse));
  motor_stage_model u_motor_stage_model (.permit_req(permit_req), .permit_pin(permit_pin));
  // verdict and end of run
  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // one comparison
  task chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    tests_run++;
    if (sv !== ev) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, ev, sv);
    end
  endtask : chk
  // one single transfer, waits on hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin n_fail++; summarize; end
  endtask : ahb
  // read status until a mode shows
  task automatic poll(input logic [5:0] m);
    int i;
    for (i = 0; i < 400; i++) begin
      ahb(1'b0, STATUS_OFS, 32'h0);
      seen |= rd[5:0];
      if (rd[5:0] === m) break;
    end
    if (i == 400) begin n_fail++; summarize; end
  endtask : poll
  // frequency must reach zero within lim cycles
  task automatic wfz(input int lim);
    int i;
    for (i = 0; i < lim && out_freq !== 16'h0; i++) @(posedge hclk);
    chk("stop time", {31'h0, i < lim}, 32'h1);
  endtask : wfz
  // boost seen at the motor stage
  function automatic logic [15:0] exp_boost(logic [15:0] f, logic [7:0] v);
    return (f > KNEE) ? 16'h0 : {8'h0, (v > BOOST_MAX) ? BOOST_MAX : v};
  endfunction : exp_boost
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h592E3C66));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, re[i]);
    end
    ahb(1'b1, RAMP_OFS, 32'h100); ahb(1'b1, HALT_OFS, 32'h200);
    ahb(1'b1, TARGET_OFS, 32'h800); ahb(1'b1, ACC_HOLD_OFS, 32'h0003_0300);
    ahb(1'b1, DEC_HOLD_OFS, 32'h0003_0300); ahb(1'b1, CTRL_OFS, 32'h1);
    poll(ST_ACC_HOLD); chk("acc hold", out_freq, 16'h300);
    repeat (5) @(posedge hclk);
    chk("held", out_freq, 16'h300);
    poll(ST_RUN); chk("run", out_freq, 16'h800);
    seen = 6'h0; ahb(1'b1, TARGET_OFS, 32'h200); poll(ST_ACCEL); poll(ST_RUN);
    chk("setpoint drop", {seen & ST_DEC_HOLD, out_freq}, 32'h200);
    seen = 6'h0; ahb(1'b1, TARGET_OFS, 32'h800); poll(ST_ACCEL); poll(ST_RUN);
    chk("re-accel", {seen & ST_ACC_HOLD, out_freq}, 32'h800);
    ahb(1'b1, CTRL_OFS, 32'h0); poll(ST_DEC_HOLD);
    chk("dec hold", out_freq, 16'h300);
    poll(ST_IDLE); chk("stopped", out_freq, 16'h0);
    ahb(1'b1, ACC_HOLD_OFS, 32'h300); ahb(1'b1, DEC_HOLD_OFS, 32'h300);
    ahb(1'b1, CTRL_OFS, 32'hD); poll(ST_RUN);
    permit_req <= 1'b0; wfz(26);
    permit_req <= 1'b1; repeat (40) @(posedge hclk);
    chk("stays stopped", out_enable, 1'b0);
    ahb(1'b1, CTRL_OFS, 32'h0); ahb(1'b1, CTRL_OFS, 32'h15); poll(ST_RUN);
    permit_req <= 1'b0; wfz(26);
    permit_req <= 1'b1; poll(ST_RUN); chk("resumed", out_freq, 16'h800);
    ahb(1'b1, CTRL_OFS, 32'h0); ahb(1'b1, CTRL_OFS, 32'h5); poll(ST_RUN);
    permit_req <= 1'b0; wfz(6); chk("coast", out_enable, 1'b0);
    ahb(1'b1, CTRL_OFS, 32'h0); ahb(1'b1, CTRL_OFS, 32'h5);
    repeat (40) @(posedge hclk);
    chk("no permit", out_enable, 1'b0);
    permit_req <= 1'b1; ahb(1'b1, CTRL_OFS, 32'h0); poll(ST_IDLE);
    ahb(1'b1, ACC_HOLD_OFS, 32'h0003_0000); ahb(1'b1, DEC_HOLD_OFS, 32'h0);
    seen = 6'h0;
    repeat (4) begin
      tg = 16'((($urandom % 31) + 1) << 8); fw = 8'($urandom); rv = 8'($urandom);
      dir = 1'($urandom);
      ahb(1'b1, TARGET_OFS, {16'h0, tg}); ahb(1'b1, BOOST_OFS, {16'h0, rv, fw});
      ahb(1'b1, CTRL_OFS, {30'h0, dir, 1'b1});
      clk_en <= 1'b0; repeat (6) @(posedge hclk); clk_en <= 1'b1;
      poll(ST_RUN); chk("freq", out_freq, tg); chk("dir", out_reverse, dir);
      chk("boost", out_boost, exp_boost(tg, dir ? rv : fw));
      ahb(1'b1, CTRL_OFS, {30'h0, dir, 1'b0}); poll(ST_IDLE);
    end
    chk("no holds", seen & (ST_ACC_HOLD | ST_DEC_HOLD), 32'h0);
    ahb(1'b1, CTRL_OFS, 32'h20); ahb(1'b1, ACC_HOLD_OFS, 32'h0003_FFFF);
    ahb(1'b0, ACC_HOLD_OFS, 32'h0);
    chk("hold readback", rd, 32'h0003_FFFF);
    ahb(1'b1, TARGET_OFS, 32'h800); ahb(1'b1, CTRL_OFS, 32'h21);
    poll(ST_ACC_HOLD); chk("rpm clamp", out_freq, HOLD_SPEED_MAX);
    summarize;
  end
endmodule : test_drive_stop_dwell_boost_control
